/* File: hw/foff_consts.vh */
`ifndef FOFF_CONSTS_VH
`define FOFF_CONSTS_VH

// ==========================================================
// Reference point codes
`define FOFF_REF_W 3
`define FOFF_REF_WHOLE 3'h0
`define FOFF_REF_MAC 3'h1
`define FOFF_REF_IPV4 3'h2
`define FOFF_REF_IPV6 3'h3
`define FOFF_REF_UDP 3'h4

// ==========================================================
// Header layout, byte positions and lengths
`define FOFF_POS_W 16
`define FOFF_POS_ZERO 16'h0000
`define FOFF_POS_ONE 16'h0001
`define FOFF_POS_TWO 16'h0002
`define FOFF_POS_MAX 16'hFFFF
`define FOFF_MAC_HDR_LEN 16'h000E
`define FOFF_VLAN_TAG_LEN 16'h0004
`define FOFF_IPV6_HDR_LEN 16'h0028
`define FOFF_UDP_HDR_LEN 16'h0008
`define FOFF_IPV4_PROTO_OFS 16'h0009
`define FOFF_IPV6_NH_OFS 16'h0006

// ==========================================================
// Protocol codes
`define FOFF_ETYPE_IPV4 16'h0800
`define FOFF_ETYPE_IPV6 16'h86DD
`define FOFF_ETYPE_VLAN 16'h8100
`define FOFF_PROTO_UDP 8'h11

// ==========================================================
// Field widths and reset values
`define FOFF_WORD_W 16
`define FOFF_WORD_ZERO 16'h0000
`define FOFF_BYTE_ZERO 8'h00

`endif

/* File: hw/foff_filter_top.v */
`timescale 1ns/1ps
`include "foff_consts.vh"


module foff_filter_top #(
	parameter NUM_FILT = 8,
	parameter POS_W = 16
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst_b,
	// Receive byte stream
	input wire rx_valid,
	input wire rx_sof,
	input wire rx_eof,
	input wire [7:0] rx_data,
	// Port-wide settings
	input wire [`FOFF_REF_W-1:0] ref_sel,
	input wire [POS_W-1:0] byte_offset,
	// Per-filter settings
	input wire [NUM_FILT-1:0] pattern_required,
	input wire [NUM_FILT*16-1:0] match_pattern,
	input wire [NUM_FILT*16-1:0] match_mask,
	input wire [NUM_FILT-1:0] other_accept,
	// Verdicts
	output reg verdict_valid_reg,
	output reg [NUM_FILT-1:0] filter_pass_reg,
	output reg [NUM_FILT-1:0] generic_hit_reg,
	// Status
	output reg word_found_reg,
	output reg [`FOFF_WORD_W-1:0] frame_word_reg
);

	// ==========================================================
	// Masked compare, used by every filter
	function masked_eq;
		input [15:0] frame_word;
		input [15:0] pattern;
		input [15:0] mask;
		begin
			masked_eq = ((frame_word & mask) == (pattern & mask));
		end
	endfunction

	// ==========================================================
	// Reset release
	reg rst_meta_reg;
	reg rst_sync_reg;
	wire rst_sync_b;

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_sync_b = rst_sync_reg;

	// ==========================================================
	// Byte index within the frame, saturating
	reg [POS_W-1:0] cnt_reg;
	reg [POS_W-1:0] cnt_next;
	wire [POS_W-1:0] idx;

	assign idx = rx_sof ? {POS_W{1'b0}} : cnt_reg;

	always @* begin
		cnt_next = cnt_reg;
		if (rx_valid && idx != {POS_W{1'b1}}) begin
			cnt_next = idx + {{(POS_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cnt_reg <= {POS_W{1'b0}};
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// ==========================================================
	// Shared reference and word capture; one copy serves all
	// filters, which is what keeps the settings port-wide
	wire ref_ok;
	wire [POS_W-1:0] ref_pos;
	wire [`FOFF_WORD_W-1:0] word;
	wire got;

	foff_ref_tracker u_ref (
		.clk(ref_clk),
		.rst_sync_b(rst_sync_b),
		.byte_en(rx_valid),
		.sof(rx_sof),
		.idx(idx),
		.data(rx_data),
		.ref_sel(ref_sel),
		.ref_ok(ref_ok),
		.ref_pos(ref_pos)
	);

	foff_word_grab u_grab (
		.clk(ref_clk),
		.rst_sync_b(rst_sync_b),
		.byte_en(rx_valid),
		.sof(rx_sof),
		.idx(idx),
		.data(rx_data),
		.ref_ok(ref_ok),
		.ref_pos(ref_pos),
		.offset(byte_offset),
		.word_reg(word),
		.got_reg(got)
	);

	// ==========================================================
	// End of frame seen; capture regs settle one cycle later
	reg eof_d_reg;

	always @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			eof_d_reg <= 1'b0;
		end else begin
			eof_d_reg <= rx_valid && rx_eof;
		end
	end

	// ==========================================================
	// Per-filter verdicts
	reg [NUM_FILT-1:0] hit_next;
	reg [NUM_FILT-1:0] pass_next;
	integer i;

	always @* begin
		hit_next = {NUM_FILT{1'b0}};
		pass_next = {NUM_FILT{1'b0}};
		for (i = 0; i < NUM_FILT; i = i + 1) begin
			// Short frame or absent header: no word, no hit
			hit_next[i] = got && masked_eq(word, match_pattern[i*16 +: 16],
				match_mask[i*16 +: 16]);
			if (pattern_required[i]) begin
				pass_next[i] = hit_next[i] && other_accept[i];
			end else begin
				pass_next[i] = other_accept[i];
			end
		end
	end

	// Verdict holds until the next frame's verdict replaces it
	always @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			verdict_valid_reg <= 1'b0;
			filter_pass_reg <= {NUM_FILT{1'b0}};
			generic_hit_reg <= {NUM_FILT{1'b0}};
			word_found_reg <= 1'b0;
			frame_word_reg <= `FOFF_WORD_ZERO;
		end else begin
			verdict_valid_reg <= eof_d_reg;
			if (eof_d_reg) begin
				filter_pass_reg <= pass_next;
				generic_hit_reg <= hit_next;
				word_found_reg <= got;
				frame_word_reg <= word;
			end
		end
	end

endmodule // foff_filter_top

/* File: hw/foff_ref_tracker.v */
`timescale 1ns/1ps
`include "foff_consts.vh"

module foff_ref_tracker (
	// Clock and reset
	input wire clk,
	input wire rst_sync_b,
	// Byte stream
	input wire byte_en,
	input wire sof,
	input wire [`FOFF_POS_W-1:0] idx,
	input wire [7:0] data,
	// Reference choice and result
	input wire [`FOFF_REF_W-1:0] ref_sel,
	output reg ref_ok,
	output reg [`FOFF_POS_W-1:0] ref_pos
);

	reg [7:0] etype_hi_reg;
	reg [`FOFF_POS_W-1:0] mac_pos_reg;
	reg mac_known_reg;
	reg vlan_seen_reg;
	reg ip4_reg;
	reg ip6_reg;
	reg ip_known_reg;
	reg [`FOFF_POS_W-1:0] ip_pos_reg;
	reg udp_reg;

	wire [`FOFF_POS_W-1:0] proto_pos;
	wire [15:0] etype;
	wire [`FOFF_POS_W-1:0] ihl_bytes;

	assign proto_pos = mac_pos_reg + (ip4_reg ? `FOFF_IPV4_PROTO_OFS : `FOFF_IPV6_NH_OFS);
	assign etype = {etype_hi_reg, data};
	assign ihl_bytes = {10'b0, data[3:0], 2'b00};

	// ==========================================================
	// Header walk; every start is known before its first byte
	always @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			etype_hi_reg <= `FOFF_BYTE_ZERO;
			mac_pos_reg <= `FOFF_MAC_HDR_LEN;
			mac_known_reg <= 1'b0;
			vlan_seen_reg <= 1'b0;
			ip4_reg <= 1'b0;
			ip6_reg <= 1'b0;
			ip_known_reg <= 1'b0;
			ip_pos_reg <= `FOFF_POS_ZERO;
			udp_reg <= 1'b0;
		end else if (byte_en && sof) begin
			etype_hi_reg <= `FOFF_BYTE_ZERO;
			mac_pos_reg <= `FOFF_MAC_HDR_LEN;
			mac_known_reg <= 1'b0;
			vlan_seen_reg <= 1'b0;
			ip4_reg <= 1'b0;
			ip6_reg <= 1'b0;
			ip_known_reg <= 1'b0;
			ip_pos_reg <= `FOFF_POS_ZERO;
			udp_reg <= 1'b0;
		end else if (byte_en) begin
			if (!mac_known_reg && idx == mac_pos_reg - `FOFF_POS_TWO) begin
				etype_hi_reg <= data;
			end
			// One tag only; a stacked tag is left as MAC payload
			if (!mac_known_reg && idx == mac_pos_reg - `FOFF_POS_ONE) begin
				if (etype == `FOFF_ETYPE_VLAN && !vlan_seen_reg) begin
					vlan_seen_reg <= 1'b1;
					mac_pos_reg <= mac_pos_reg + `FOFF_VLAN_TAG_LEN;
				end else begin
					mac_known_reg <= 1'b1;
					ip4_reg <= (etype == `FOFF_ETYPE_IPV4);
					ip6_reg <= (etype == `FOFF_ETYPE_IPV6);
					if (etype == `FOFF_ETYPE_IPV6) begin
						ip_known_reg <= 1'b1;
						ip_pos_reg <= mac_pos_reg + `FOFF_IPV6_HDR_LEN - `FOFF_POS_ONE;
					end
				end
			end
			if (mac_known_reg && ip6_reg && ip_pos_reg != `FOFF_POS_ZERO && !udp_reg
				&& idx == mac_pos_reg) begin
				ip_pos_reg <= ip_pos_reg + `FOFF_POS_ONE;
			end
			if (mac_known_reg && ip4_reg && idx == mac_pos_reg) begin
				ip_known_reg <= 1'b1;
				ip_pos_reg <= mac_pos_reg + ihl_bytes;
			end
			if (mac_known_reg && (ip4_reg || ip6_reg) && idx == proto_pos) begin
				udp_reg <= (data == `FOFF_PROTO_UDP);
			end
		end
	end

	// ==========================================================
	// Reference select; absent headers give no reference
	always @* begin
		ref_ok = 1'b0;
		ref_pos = `FOFF_POS_ZERO;
		case (ref_sel)
			`FOFF_REF_WHOLE: begin
				ref_ok = 1'b1;
				ref_pos = `FOFF_POS_ZERO;
			end
			`FOFF_REF_MAC: begin
				ref_ok = mac_known_reg;
				ref_pos = mac_pos_reg;
			end
			`FOFF_REF_IPV4: begin
				ref_ok = ip4_reg && ip_known_reg;
				ref_pos = ip_pos_reg;
			end
			`FOFF_REF_IPV6: begin
				ref_ok = ip6_reg && ip_known_reg && idx > mac_pos_reg;
				ref_pos = ip_pos_reg;
			end
			`FOFF_REF_UDP: begin
				ref_ok = udp_reg && ip_known_reg;
				ref_pos = ip_pos_reg + `FOFF_UDP_HDR_LEN;
			end
			default: begin
				ref_ok = 1'b0;
				ref_pos = `FOFF_POS_ZERO;
			end
		endcase
	end

endmodule // foff_ref_tracker

/* File: hw/foff_word_grab.v */
`timescale 1ns/1ps
`include "foff_consts.vh"

module foff_word_grab (
	// Clock and reset
	input wire clk,
	input wire rst_sync_b,
	// Byte stream
	input wire byte_en,
	input wire sof,
	input wire [`FOFF_POS_W-1:0] idx,
	input wire [7:0] data,
	// Position
	input wire ref_ok,
	input wire [`FOFF_POS_W-1:0] ref_pos,
	input wire [`FOFF_POS_W-1:0] offset,
	// Captured word
	output reg [`FOFF_WORD_W-1:0] word_reg,
	output reg got_reg
);

	reg hi_got_reg;
	reg [`FOFF_WORD_W-1:0] word_next;
	reg got_next;
	reg hi_got_next;
	wire [`FOFF_POS_W:0] tgt;

	// Wide sum so a far offset cannot wrap onto early bytes
	assign tgt = {1'b0, ref_pos} + {1'b0, offset};

	always @* begin
		word_next = word_reg;
		// Sof counts only with a byte; it may linger over idle gaps
		got_next = (byte_en && sof) ? 1'b0 : got_reg;
		hi_got_next = (byte_en && sof) ? 1'b0 : hi_got_reg;
		if (byte_en) begin
			if (ref_ok && !hi_got_next && {1'b0, idx} == tgt) begin
				word_next[15:8] = data;
				hi_got_next = 1'b1;
			end else if (hi_got_next && !got_next
				&& {1'b0, idx} == tgt + {1'b0, `FOFF_POS_ONE}) begin
				word_next[7:0] = data;
				got_next = 1'b1;
			end
		end
	end

	always @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			word_reg <= `FOFF_WORD_ZERO;
			got_reg <= 1'b0;
			hi_got_reg <= 1'b0;
		end else begin
			word_reg <= word_next;
			got_reg <= got_next;
			hi_got_reg <= hi_got_next;
		end
	end

endmodule // foff_word_grab

/* File: tb/foff_filter_monitor.sv */
`timescale 1ns/1ps
// ==========
// Verdict checker
module foff_filter_monitor #(
	parameter NUM_FILT = 8,
	parameter POS_W = 16
) (
	// Clock and stream
	input wire ref_clk,
	input wire rst_b,
	input wire rx_valid,
	input wire rx_eof,
	// Settings
	input wire [NUM_FILT-1:0] pattern_required,
	input wire [NUM_FILT*16-1:0] match_pattern,
	input wire [NUM_FILT*16-1:0] match_mask,
	input wire [NUM_FILT-1:0] other_accept,
	// Verdicts
	input wire verdict_valid_reg,
	input wire [NUM_FILT-1:0] filter_pass_reg,
	input wire [NUM_FILT-1:0] generic_hit_reg,
	input wire word_found_reg,
	input wire [15:0] frame_word_reg
);
	// Settings are taken one cycle before the verdict
	reg [NUM_FILT*16-1:0] pat_d, msk_d;
	reg [NUM_FILT-1:0] hit_x;
	integer i;
	always @(posedge ref_clk) begin
		pat_d <= match_pattern;
		msk_d <= match_mask;
	end
	always @* begin
		for (i = 0; i < NUM_FILT; i = i + 1)
			hit_x[i] = word_found_reg &&
				(((frame_word_reg ^ pat_d[16*i +: 16]) & msk_d[16*i +: 16]) == 16'h0000);
	end
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_eof; rx_valid && rx_eof; endsequence
	sequence s_idle; !rx_valid ##1 !rx_valid; endsequence
	property p_lat; s_eof |-> ##2 verdict_valid_reg; endproperty
	a_lat: assert property (p_lat) else $error("late verdict");
	property p_cause; verdict_valid_reg |-> $past(rx_valid && rx_eof, 2); endproperty
	a_cause: assert property (p_cause) else $error("stray verdict");
	property p_quiet; s_idle |=> !verdict_valid_reg; endproperty
	a_quiet: assert property (p_quiet) else $error("verdict when idle");
	property p_hold; !verdict_valid_reg |->
		$stable({filter_pass_reg, generic_hit_reg, word_found_reg, frame_word_reg}); endproperty
	a_hold: assert property (p_hold) else $error("verdict not held");
	property p_pass; verdict_valid_reg |-> filter_pass_reg ==
		($past(other_accept) & (~$past(pattern_required) | generic_hit_reg)); endproperty
	a_pass: assert property (p_pass) else $error("bad pass");
	property p_hit; verdict_valid_reg |-> generic_hit_reg == hit_x; endproperty
	a_hit: assert property (p_hit) else $error("bad hit");
	property p_miss; verdict_valid_reg && !word_found_reg |-> generic_hit_reg == '0; endproperty
	a_miss: assert property (p_miss) else $error("hit without word");
	property p_rst; disable iff (1'b0) !rst_b && $past(!rst_b) |->
		!verdict_valid_reg && !word_found_reg;
	endproperty
	a_rst: assert property (p_rst) else $error("verdict in reset");
endmodule // foff_filter_monitor

bind foff_filter_top foff_filter_monitor #(.NUM_FILT(NUM_FILT), .POS_W(POS_W)) i_mon (
	.ref_clk, .rst_b, .rx_valid, .rx_eof, .pattern_required, .match_pattern, .match_mask,
	.other_accept, .verdict_valid_reg, .filter_pass_reg, .generic_hit_reg, .word_found_reg,
	.frame_word_reg);

/* File: tb/foff_rx_model.sv */
`timescale 1ns/1ps
// ==========
// Receive path byte source
module foff_rx_model (
	// Clock
	input wire ref_clk,
	// Byte stream
	output reg rx_valid,
	output reg rx_sof,
	output reg rx_eof,
	output reg [7:0] rx_data
);
	reg [7:0] mem [0:127];
	initial {rx_valid, rx_sof, rx_eof, rx_data} = 11'h000;
	// Idle cycles carry the inverted byte, never a stale copy
	task send(input integer len, input integer gap);
		integer n;
		begin
			for (n = 0; n < len; n = n + 1) begin
				@(negedge ref_clk);
				rx_valid <= 1'b1;
				rx_sof <= (n == 0);
				rx_eof <= (n == len - 1);
				rx_data <= mem[n];
				if (gap != 0 && n < len - 1) begin
					@(negedge ref_clk);
					rx_valid <= 1'b0;
					rx_data <= ~mem[n];
				end
			end
			@(negedge ref_clk);
			rx_valid <= 1'b0;
			rx_eof <= 1'b0;
			rx_data <= ~rx_data;
		end
	endtask
endmodule // foff_rx_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "foff_consts.vh"
// ==========
// Bench top
module tb;
	reg ref_clk, rst_b;
	reg [`FOFF_REF_W-1:0] ref_sel;
	reg [15:0] byte_offset;
	reg [7:0] pattern_required, other_accept;
	reg [127:0] match_pattern, match_mask;
	wire rx_valid, rx_sof, rx_eof, verdict_valid_reg, word_found_reg;
	wire [7:0] rx_data, filter_pass_reg, generic_hit_reg;
	wire [15:0] frame_word_reg;
	integer fails, compares, i;
	foff_rx_model i_src (.ref_clk, .rx_valid, .rx_sof, .rx_eof, .rx_data);
	foff_filter_top i_dut (.ref_clk, .rst_b, .rx_valid, .rx_sof, .rx_eof, .rx_data, .ref_sel,
		.byte_offset, .pattern_required, .match_pattern, .match_mask, .other_accept,
		.verdict_valid_reg, .filter_pass_reg, .generic_hit_reg, .word_found_reg,
		.frame_word_reg);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task chk(input [15:0] got, input [15:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task results;
		begin
			$display("compares=%0d fails=%0d", compares, fails);
			if (fails == 0 && compares > 0) begin
				$display("ALL CHECKS OK");
			end else begin
				$display("CHECKS NOT OK");
			end
			$finish;
		end
	endtask
	// Bounded wait for the verdict pulse
	task frame(input integer len, input integer gap);
		integer n;
		begin
			i_src.send(len, gap);
			n = 0;
			while (verdict_valid_reg !== 1'b1 && n < 8) begin
				@(posedge ref_clk);
				#1;
				n = n + 1;
			end
			if (verdict_valid_reg !== 1'b1) begin
				fails = fails + 1;
				results;
			end
		end
	endtask
	task t_one(input [15:0] et, input integer nh, input [`FOFF_REF_W-1:0] rs,
		input integer base, input integer off, input integer len);
		reg [15:0] w;
		reg ok;
		begin
			for (i = 0; i < 128; i = i + 1)
				i_src.mem[i] = i[7:0];
			{i_src.mem[12], i_src.mem[13], i_src.mem[14], i_src.mem[nh]} = {et, 16'h4511};
			ok = base >= 0 && base + off + 1 < len;
			w = ok ? {i_src.mem[base + off], i_src.mem[base + off + 1]} : 16'h0000;
			@(negedge ref_clk);
			ref_sel = rs;
			byte_offset = off[15:0];
			pattern_required = 8'h0f;
			other_accept = 8'hcc;
			match_mask = {8{16'hffff}};
			match_pattern = {8{w}};
			// Gap after byte 0 leaves sof high while idle
			frame(len, off == 0);
			chk(word_found_reg, ok);
			chk(generic_hit_reg, ok ? 8'hff : 8'h00);
			chk(filter_pass_reg, ok ? 8'hcc : 8'hc0);
			if (ok)
				chk(frame_word_reg, w);
			$display("test ref %0d offset %0d done", rs, off);
		end
	endtask
	task t_whole;
		begin
			@(negedge ref_clk);
			ref_sel = `FOFF_REF_WHOLE;
			byte_offset = 16'h0005;
			pattern_required = 8'hf0;
			for (i = 0; i < 8; i = i + 1) begin
				match_pattern[16*i +: 16] = 16'h0506 ^ (16'h0001 << i);
				match_mask[16*i +: 16] = i[0] ? 16'hffff : ~(16'h0001 << i);
			end
			frame(20, 1);
			chk(frame_word_reg, 16'h0506);
			chk(generic_hit_reg, 8'h55);
			chk(filter_pass_reg, 8'h4c);
			$display("test masks done");
		end
	endtask
	initial begin
		fails = 0;
		compares = 0;
		rst_b = 1'b0;
		ref_sel = `FOFF_REF_WHOLE;
		byte_offset = 16'h0000;
		{pattern_required, other_accept, match_pattern, match_mask} = 272'h0;
		repeat (2) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge ref_clk);
		t_one(16'h0c0d, 23, `FOFF_REF_WHOLE, 0, 0, 2);
		t_one(16'h0c0d, 23, `FOFF_REF_WHOLE, 0, 19, 20);
		t_one(`FOFF_ETYPE_IPV4, 23, `FOFF_REF_MAC, 14, 0, 80);
		t_one(`FOFF_ETYPE_IPV4, 23, `FOFF_REF_IPV4, 34, 3, 80);
		t_one(`FOFF_ETYPE_IPV4, 23, `FOFF_REF_UDP, 42, 2, 80);
		t_one(`FOFF_ETYPE_IPV6, 20, `FOFF_REF_IPV6, 54, 1, 80);
		t_one(`FOFF_ETYPE_IPV6, 20, `FOFF_REF_UDP, 62, 4, 80);
		t_one(`FOFF_ETYPE_IPV4, 23, `FOFF_REF_IPV6, -1, 0, 80);
		t_one(`FOFF_ETYPE_VLAN, 23, `FOFF_REF_MAC, 18, 0, 80);
		t_one(`FOFF_ETYPE_IPV4, 23, 3'h7, -1, 0, 80);
		t_whole;
		results;
	end
endmodule // tb
